// ### rtl/lane_mux_pkg.sv
// shared constants for the byte-lane pin logic
//
// How it works
// - as master, lanes mark active write bytes
// - mode input selects read/write byte enables
// - 8-bit region: lanes 2,3 address, lane0 enable
// - 16-bit region: lane0 high, lane1 low byte
// - 32-bit region: four lanes enable bytes 0-3
// - foreign master: lanes 0,1 give bank select
// - foreign master: lanes 2,3 give byte address
`default_nettype none

package lane_mux_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   localparam int unsigned LANE_COUNT = 4;
   localparam int unsigned SYNC_STAGES = 2;

   // region width codes
   localparam logic [1:0] WIDTH_8 = 2'h0;
   localparam logic [1:0] WIDTH_16 = 2'h1;
   localparam logic [1:0] WIDTH_32 = 2'h2;

   // access size codes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // values after reset, plus the output-enable level while driving
   localparam logic [3:0] LANE_OUT_RST = 4'h0;
   localparam logic [3:0] LANE_OE_N_RST = 4'hF;
   localparam logic [3:0] LANE_OE_N_DRIVE = 4'h0;
   localparam logic [1:0] BANK_SEL_RST = 2'h0;
   localparam logic [1:0] BYTE_ADDR_RST = 2'h0;

endpackage

`default_nettype wire

// ### rtl/lane_pin_sync.sv
// two-flop synchroniser for the shared lane pins
`timescale 1ns/1ps
`default_nettype none

module lane_pin_sync #(
   parameter int unsigned WIDTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output var  logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // meta_reg feeds sync_reg only
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule // lane_pin_sync

`default_nettype wire

// ### rtl/byte_lane_enable_mux.sv
// byte-lane enable / address pin multiplexer of the external bus
`timescale 1ns/1ps
`default_nettype none

module byte_lane_enable_mux #(
   parameter int unsigned LANES = lane_mux_pkg::LANE_COUNT
) (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       bus_master_i,
   input  wire logic       rw_mode_i,
   input  wire logic       access_valid_i,
   input  wire logic       access_write_i,
   input  wire logic       write_strobe_i,
   input  wire logic [1:0] region_width_i,
   input  wire logic [1:0] access_size_i,
   input  wire logic [1:0] addr_lo_i,
   input  wire logic [3:0] lane_in_i,
   output var  logic [3:0] lane_out_o,
   output var  logic [3:0] lane_oe_n_o,
   output var  logic [1:0] bank_sel_o,
   output var  logic [1:0] ext_byte_addr_o,
   output var  logic       page_cross_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // master side: decode of the enables

   logic [3:0] lane_out_reg;
   logic [3:0] lane_out_next;
   logic [3:0] lane_oe_n_reg;
   logic [3:0] lane_oe_n_next;
   logic [3:0] mask32;
   logic [3:0] mask16;
   logic [3:0] mask8;
   logic [3:0] lanes_w32;
   logic [3:0] lanes_w16;
   logic [3:0] lanes_w8;
   logic       enable_gate;
   logic       is_byte;
   logic       is_half;
   logic       is_word;

   assign is_byte = (access_size_i == lane_mux_pkg::SIZE_BYTE);
   assign is_half = (access_size_i == lane_mux_pkg::SIZE_HALF);
   assign is_word = (access_size_i == lane_mux_pkg::SIZE_WORD);

   // write-only mode waits for the data strobe; read/write mode follows the address phase
   assign enable_gate = rw_mode_i ? access_valid_i
                                  : (access_valid_i & access_write_i & write_strobe_i);

   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_lane
         localparam logic [1:0] LANE_IDX = 2'(k);
         assign mask32[k] = is_word
                          | (is_half & (addr_lo_i[1] == LANE_IDX[1]))
                          | (is_byte & (addr_lo_i == LANE_IDX));
      end
   endgenerate

   // lane0 high byte (even address), lane1 low byte (odd address)
   assign mask16 = {2'b00, ~is_byte | addr_lo_i[0], ~is_byte | ~addr_lo_i[0]};
   assign mask8 = 4'h1;

   assign lanes_w32 = mask32 & {4{enable_gate}};
   // address lanes carry A30 on lane2, A31 on lane3 whatever the gate
   assign lanes_w16 = {addr_lo_i[0], addr_lo_i[1], mask16[1:0] & {2{enable_gate}}};
   assign lanes_w8 = {addr_lo_i[0], addr_lo_i[1], 1'b0, mask8[0] & enable_gate};

   // unknown width code drives nothing active
   assign lane_out_next = !bus_master_i ? lane_mux_pkg::LANE_OUT_RST :
                          (region_width_i == lane_mux_pkg::WIDTH_8)  ? lanes_w8 :
                          (region_width_i == lane_mux_pkg::WIDTH_16) ? lanes_w16 :
                          (region_width_i == lane_mux_pkg::WIDTH_32) ? lanes_w32 :
                          lane_mux_pkg::LANE_OUT_RST;

   assign lane_oe_n_next = bus_master_i ? lane_mux_pkg::LANE_OE_N_DRIVE
                                        : lane_mux_pkg::LANE_OE_N_RST;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         lane_out_reg  <= lane_mux_pkg::LANE_OUT_RST;
         lane_oe_n_reg <= lane_mux_pkg::LANE_OE_N_RST;
      end else begin
         lane_out_reg  <= lane_out_next;
         lane_oe_n_reg <= lane_oe_n_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // foreign-master side: address inputs

   logic [3:0] lane_sync;
   logic [1:0] bank_sel_reg;
   logic [1:0] bank_sel_next;
   logic [1:0] byte_addr_reg;
   logic [1:0] byte_addr_next;
   logic       addr_seen_reg;
   logic       addr_seen_next;
   logic       page_cross_reg;
   logic       page_cross_next;
   logic [1:0] sampled_byte;

   lane_pin_sync #(
      .WIDTH (LANES)
   ) u_sync (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .async_i (lane_in_i),
      .sync_o  (lane_sync)
   );

   // lane0 is A4 (msb of bank index), lane1 is A5
   assign bank_sel_next = bus_master_i ? bank_sel_reg : {lane_sync[0], lane_sync[1]};
   assign sampled_byte = {lane_sync[2], lane_sync[3]};
   assign byte_addr_next = bus_master_i ? byte_addr_reg : sampled_byte;
   assign addr_seen_next = ~bus_master_i;
   // wrap of A30:31 downward means the next word of a sequential run was entered
   assign page_cross_next = ~bus_master_i & addr_seen_reg & (sampled_byte < byte_addr_reg);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bank_sel_reg   <= lane_mux_pkg::BANK_SEL_RST;
         byte_addr_reg  <= lane_mux_pkg::BYTE_ADDR_RST;
         addr_seen_reg  <= 1'b0;
         page_cross_reg <= 1'b0;
      end else begin
         bank_sel_reg   <= bank_sel_next;
         byte_addr_reg  <= byte_addr_next;
         addr_seen_reg  <= addr_seen_next;
         page_cross_reg <= page_cross_next;
      end
   end

   assign lane_out_o      = lane_out_reg;
   assign lane_oe_n_o     = lane_oe_n_reg;
   assign bank_sel_o      = bank_sel_reg;
   assign ext_byte_addr_o = byte_addr_reg;
   assign page_cross_o    = page_cross_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   sequence s_master_write_cycle;
      bus_master_i && access_valid_i && access_write_i && write_strobe_i;
   endsequence

   sequence s_foreign_run;
      (!bus_master_i) [*4];
   endsequence

   lane_release_a: assert property (
      !bus_master_i |=> (lane_oe_n_o == 4'hF) && (lane_out_o == 4'h0))
      else $error("lane drivers not released without bus ownership");

   lane_drive_a: assert property (
      bus_master_i |=> lane_oe_n_o == 4'h0)
      else $error("lane drivers off while bus master");

   word_write_a: assert property (
      s_master_write_cycle ##0 (region_width_i == 2'h2) && (access_size_i == 2'h2)
      |=> lane_out_o == 4'hF)
      else $error("word write on wide region lacks all four enables");

   wide_byte_a: assert property (
      s_master_write_cycle ##0 (region_width_i == 2'h2) && (access_size_i == 2'h0)
      |=> $onehot(lane_out_o) && lane_out_o[$past(addr_lo_i)])
      else $error("byte write on wide region enables wrong lane");

   narrow_lanes_a: assert property (
      bus_master_i && (region_width_i == 2'h0)
      |=> (lane_out_o[1] == 1'b0)
          && (lane_out_o[3:2] == {$past(addr_lo_i[0]), $past(addr_lo_i[1])}))
      else $error("8-bit region lanes 1-3 wrong");

   half_lanes_a: assert property (
      s_master_write_cycle ##0 (region_width_i == 2'h1) && (access_size_i == 2'h0)
      |=> lane_out_o[1:0] == ($past(addr_lo_i[0]) ? 2'b10 : 2'b01))
      else $error("16-bit region high/low byte enable swapped");

   rw_mode_read_a: assert property (
      bus_master_i && access_valid_i && !access_write_i && (region_width_i == 2'h2)
      && (access_size_i == 2'h2)
      |=> lane_out_o == ($past(rw_mode_i) ? 4'hF : 4'h0))
      else $error("read enables do not follow the mode setting");

   bank_select_a: assert property (
      s_foreign_run |-> bank_sel_o == {$past(lane_in_i[0], 3), $past(lane_in_i[1], 3)})
      else $error("bank select not taken from lanes 0 and 1");

   byte_addr_a: assert property (
      s_foreign_run |-> ext_byte_addr_o == {$past(lane_in_i[2], 3), $past(lane_in_i[3], 3)})
      else $error("byte address not taken from lanes 2 and 3");

   page_cross_a: assert property (
      page_cross_o |-> !$past(bus_master_i) && (ext_byte_addr_o < $past(ext_byte_addr_o)))
      else $error("page crossing flagged without a downward wrap");

   wo_gate_a: assert property (
      bus_master_i && !rw_mode_i && !(access_valid_i && access_write_i && write_strobe_i)
      && (region_width_i == 2'h2)
      |=> lane_out_o == 4'h0)
      else $error("write-only enables active outside a strobed write");

   wide_half_a: assert property (
      s_master_write_cycle ##0 (region_width_i == 2'h2) && (access_size_i == 2'h1)
      |=> lane_out_o == ($past(addr_lo_i[1]) ? 4'hC : 4'h3))
      else $error("half-word write on wide region enables wrong lane pair");

   no_region_a: assert property (
      bus_master_i && (region_width_i == 2'h3) |=> lane_out_o == 4'h0)
      else $error("enables active for an unconfigured region width");

   held_addr_a: assert property (
      bus_master_i |=> $stable(bank_sel_o) && $stable(ext_byte_addr_o))
      else $error("foreign address inputs captured while bus master");

endmodule // byte_lane_enable_mux

`default_nettype wire

// ### sim/ext_master_model.sv
// external bus master and lane wire model
`timescale 1ns/1ps
`default_nettype none

module ext_master_model (
   input  wire logic       clk_i,
   input  wire logic       drive_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [3:0] lane_out_i,
   input  wire logic [3:0] lane_oe_n_i,
   output var  logic [3:0] lane_o
);
   logic [3:0] last_reg = 4'h0;
   // released lanes show the inverse of the last level really driven, without toggling
   always @(posedge clk_i) begin
      for (int k = 0; k < 4; k++) begin
         if (!lane_oe_n_i[k] || drive_i) last_reg[k] <= lane_o[k];
      end
   end
   // a floating lane must not keep its last level
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         if (!lane_oe_n_i[k]) lane_o[k] = lane_out_i[k];
         else if (drive_i) lane_o[k] = addr_i[k];
         else lane_o[k] = ~last_reg[k];
      end
   end
endmodule // ext_master_model
`default_nettype wire

// ### sim/byte_lane_enable_mux_test.sv
// self-checking bench of the byte-lane pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module byte_lane_enable_mux_test;
   logic       clk_i = 1'h0, srst_i = 1'h1, m = 1'h0, rw = 1'h0, v = 1'h0, w = 1'h0, s = 1'h0;
   logic [1:0] wd = 2'h0, sz = 2'h0, ad = 2'h0, bank, eba;
   logic [3:0] lane, lout, oen, xaddr = 4'h0;
   logic       xdrv = 1'h0, pc;
   int         failures = 0, checks = 0, n;

   byte_lane_enable_mux u_byte_lane_enable_mux (.clk_i(clk_i), .srst_i(srst_i),
      .bus_master_i(m), .rw_mode_i(rw), .access_valid_i(v), .access_write_i(w),
      .write_strobe_i(s), .region_width_i(wd), .access_size_i(sz), .addr_lo_i(ad),
      .lane_in_i(lane), .lane_out_o(lout), .lane_oe_n_o(oen), .bank_sel_o(bank),
      .ext_byte_addr_o(eba), .page_cross_o(pc));
   ext_master_model u_ext_master_model (.clk_i(clk_i), .drive_i(xdrv), .addr_i(xaddr),
      .lane_out_i(lout), .lane_oe_n_i(oen), .lane_o(lane));

   ////////////////////////////////////////////////////////////////////////////////
   initial forever #10 clk_i = ~clk_i;

   task automatic end_sim;
      if (failures == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   // called at a falling edge; returns one cycle later with outputs settled
   task automatic drv(input logic [7:0] c, input logic [1:0] nw, nz, na);
      {m, rw, v, w, s} = c[4:0];
      wd = nw;
      sz = nz;
      ad = na;
      @(negedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_w32;
      for (int k = 0; k < 4; k++) begin
         drv(8'h1F, lane_mux_pkg::WIDTH_32, lane_mux_pkg::SIZE_BYTE, 2'(k));
         chk("w32 byte", 4'(4'h1 << k), lout);
      end
      drv(8'h1F, lane_mux_pkg::WIDTH_32, lane_mux_pkg::SIZE_HALF, 2'h2);
      chk("w32 half", 4'hC, lout);
      drv(8'h1F, lane_mux_pkg::WIDTH_32, lane_mux_pkg::SIZE_WORD, 2'h0);
      chk("w32 word", 4'hF, lout);
      chk("drive oe", 4'h0, oen);
      drv(8'h17, lane_mux_pkg::WIDTH_32, lane_mux_pkg::SIZE_WORD, 2'h0);
      chk("wo write", 4'hF, lout);
      drv(8'h15, lane_mux_pkg::WIDTH_32, lane_mux_pkg::SIZE_WORD, 2'h0);
      chk("wo read", 4'h0, lout);
      drv(8'h16, lane_mux_pkg::WIDTH_32, lane_mux_pkg::SIZE_WORD, 2'h0);
      chk("wo nostrobe", 4'h0, lout);
      drv(8'h1C, lane_mux_pkg::WIDTH_32, lane_mux_pkg::SIZE_WORD, 2'h0);
      chk("rw read", 4'hF, lout);
   endtask

   task automatic t_narrow;
      for (int a = 0; a < 4; a++) begin
         drv(8'h1C, lane_mux_pkg::WIDTH_16, lane_mux_pkg::SIZE_BYTE, 2'(a));
         chk("w16 byte", {a[0], a[1], a[0], ~a[0]}, lout);
         drv(8'h1C, lane_mux_pkg::WIDTH_16, lane_mux_pkg::SIZE_HALF, 2'(a));
         chk("w16 half", {a[0], a[1], 2'h3}, lout);
         drv(8'h1F, lane_mux_pkg::WIDTH_8, lane_mux_pkg::SIZE_BYTE, 2'(a));
         chk("w8 byte", {a[0], a[1], 2'h1}, lout);
      end
      drv(8'h1F, 2'h3, lane_mux_pkg::SIZE_WORD, 2'h0);
      chk("no region", 4'h0, lout);
   endtask

   // counts page-crossing pulses over five cycles after the foreign master moves to the new address xa
   task automatic t_foreign(input logic [3:0] xa, input logic [3:0] eb, input int np);
      xaddr = xa;
      n = 0;
      repeat (5) begin
         drv(8'h00, 2'h0, 2'h0, 2'h0);
         if (pc === 1'h1) n++;
      end
      chk("release", 4'hF, oen);
      chk("bank sel", {2'h0, xa[0], xa[1]}, {2'h0, bank});
      chk("byte addr", eb, {2'h0, eba});
      chk("page cross", 4'(np), 4'(n));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge clk_i);
      srst_i = 1'h0;
      chk("rst oe", lane_mux_pkg::LANE_OE_N_RST, oen);
      chk("rst out", 4'h0, lout);
      t_w32();
      t_narrow();
      drv(8'h00, 2'h0, 2'h0, 2'h0);
      xdrv = 1'h1;
      xaddr = 4'hD;
      repeat (4) drv(8'h00, 2'h0, 2'h0, 2'h0);
      t_foreign(4'h1, 4'h0, 1);
      t_foreign(4'hA, 4'h1, 0);
      end_sim();
   end

   initial begin
      #(20 * 2000);
      failures++;
      end_sim();
   end
endmodule // byte_lane_enable_mux_test
`default_nettype wire
